// *** hdl/ssb_consts.svh ***
// Setting indices, baud rates and the summary of the settings bank.
// What this block does
// - Analog channel byte: on, invert, average, math enable, math subtract/multiply.
// - Logic byte bit 1 enables pull resistor, bit 2 picks up or down.
// - Logic byte bits 3-7: thick low, invert, serial, parallel, ASCII display.
// - Single trigger only acts while normal trigger is also set.
// - Trigger bits 5-7 pick slope, window, edge; all clear means dual edge.
// - Trigger bits 2-4: auto trigger, direction, round sniffer.
// - Cursor byte: roll, auto, track, vertical, reference, single sniffer capture.
// - Display bits 1:0 encode grid: none, dots, follow trigger, graticule.
// - Display bit 6 line or pixel; bits 2-5 and 7 display options.
// - Spectrum bits 5-7 enable scope, XY, spectrum views; none means meter.
// - Sweep byte: acceleration, direction, ping-pong and four swept parameters.
// - Sniffer bits 2:0 select baud rate from 1200 to 115200.
// - Sniffer bit 3 clock polarity, bit 4 clock phase.
// - Sniffer bit 5 enables parity, bit 6 selects odd parity.
// - Sniffer bit 7 selects two stop bits, else one.
// - Status bit 0 abandons any trigger wait in progress.
// - Status bit 1 reloads the waveform generator parameters.
// - Status bit 2 reapplies the acquisition parameters.
// - Status bit 3 enters sniffer mode; bits 4, 5 report stopped, triggered.
// - Status bits 6, 7 pick DC or peak-to-peak meter; else frequency.
// - Writes below index 14 request acquisition update; above 34 generator update.
`ifndef SSB_CONSTS_SVH
`define SSB_CONSTS_SVH

// ------------------------------------------------------------
// Setting indices
// ------------------------------------------------------------
`define SSB_IDX_CH1 6'h01
`define SSB_IDX_CH2 6'h02
`define SSB_IDX_LOGIC 6'h03
`define SSB_IDX_TRIG 6'h05
`define SSB_IDX_CURS 6'h06
`define SSB_IDX_DISP 6'h07
`define SSB_IDX_SPEC 6'h08
`define SSB_IDX_SWEEP 6'h09
`define SSB_IDX_SNIFF 6'h0a
`define SSB_IDX_STAT 6'h0b
`define SSB_IDX_ACQ_LIM 6'h0e
`define SSB_IDX_GEN_LIM 6'h22

// ------------------------------------------------------------
// Reset values and baud rates
// ------------------------------------------------------------
`define SSB_BYTE_RST 8'h00
`define SSB_BAUD_1200 17'h004b0
`define SSB_BAUD_2400 17'h00960
`define SSB_BAUD_4800 17'h012c0
`define SSB_BAUD_9600 17'h02580
`define SSB_BAUD_19200 17'h04b00
`define SSB_BAUD_38400 17'h09600
`define SSB_BAUD_57600 17'h0e100
`define SSB_BAUD_115200 17'h1c200

`endif

// *** hdl/ssb_pkg.sv ***
// Types for the bit layouts and decoded views of the settings bank.
package ssb_pkg;

   // ---------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------
   typedef enum logic [1:0] {
      TRIG_DUAL = 2'b00, TRIG_SLOPE = 2'b01,
      TRIG_WINDOW = 2'b10, TRIG_EDGE = 2'b11
   } ssb_trig_mode_t;
   typedef enum logic [1:0] {
      GRID_NONE = 2'b00, GRID_DOTS = 2'b01,
      GRID_FOLLOW = 2'b10, GRID_GRATICULE = 2'b11
   } ssb_grid_t;
   typedef enum logic [1:0] {
      WIN_NONE = 2'b00, WIN_HAMMING = 2'b01,
      WIN_HANN = 2'b10, WIN_BLACKMAN = 2'b11
   } ssb_win_t;
   typedef enum logic [1:0] {
      MTR_FREQ = 2'b00, MTR_VDC = 2'b01, MTR_VPP = 2'b10
   } ssb_meter_t;
   typedef enum logic [2:0] {
      BAUD_1200 = 3'b000, BAUD_2400 = 3'b001, BAUD_4800 = 3'b010,
      BAUD_9600 = 3'b011, BAUD_19200 = 3'b100, BAUD_38400 = 3'b101,
      BAUD_57600 = 3'b110, BAUD_115200 = 3'b111
   } ssb_baud_t;

   // ---------------------------------------------------------
   // Byte layouts, most significant bit first
   // ---------------------------------------------------------
   typedef struct packed {
      logic math_sub; logic math_on; logic average; logic invert;
      logic ac_dc; logic bw_limit; logic probe_x10; logic on;
   } ssb_chan_t;
   typedef struct packed {
      logic ascii; logic par_dec; logic ser_dec; logic invert;
      logic thick_low; logic pull_up; logic pull_en; logic on;
   } ssb_logic_t;
   typedef struct packed {
      logic edge_sel; logic window; logic slope; logic round;
      logic dir; logic auto_trig; logic single; logic normal;
   } ssb_trig_t;
   typedef struct packed {
      logic sniff_single; logic ref_wave; logic vert; logic h2;
      logic h1; logic track; logic auto_curs; logic roll;
   } ssb_curs_t;
   typedef struct packed {
      logic show; logic line; logic persist; logic flip;
      logic invert; logic elastic; ssb_grid_t grid;
   } ssb_disp_t;
   typedef struct packed {
      logic fft; logic xy; logic scope; logic iq;
      logic vlog; logic blackman; logic hann; logic hamming;
   } ssb_spec_t;
   typedef struct packed {
      logic duty; logic offset; logic amp; logic freq;
      logic ping_pong; logic sweep_dir; logic accel; logic accel_dir;
   } ssb_sweep_t;
   typedef struct packed {
      logic two_stop; logic odd; logic parity_en; logic clock_phase;
      logic clock_pol; ssb_baud_t baud;
   } ssb_sniff_t;
   typedef struct packed {
      logic vpp; logic vdc; logic triggered; logic stopped;
      logic go_sniffer; logic upd_acq; logic upd_gen; logic abort;
   } ssb_stat_t;

   // ---------------------------------------------------------
   // Decoded views handed to the instrument
   // ---------------------------------------------------------
   typedef struct packed {
      ssb_trig_mode_t mode; logic normal; logic single_eff;
      logic auto_trig; logic dir; logic round;
   } ssb_trig_cfg_t;
   typedef struct packed {
      ssb_win_t win; logic vlog; logic iq; logic scope;
      logic xy; logic fft; logic meter;
   } ssb_spec_cfg_t;
   typedef struct packed {
      logic [16:0] baud_rate; logic clock_pol; logic clock_phase;
      logic parity_en; logic odd; logic two_stop;
   } ssb_sniff_cfg_t;

endpackage

// *** hdl/ssb_bank.sv ***
// Settings bank of bitfield bytes with decoded configuration outputs.
`include "ssb_consts.svh"

module ssb_bank (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [5:0] idx_in,
   input wire logic [7:0] wr_data_in,
   input wire logic acq_stopped_in,
   input wire logic triggered_in,
   output logic [7:0] rd_data_out,
   output ssb_pkg::ssb_chan_t ch1_out,
   output ssb_pkg::ssb_chan_t ch2_out,
   output ssb_pkg::ssb_logic_t logic_out,
   output ssb_pkg::ssb_trig_cfg_t trig_out,
   output ssb_pkg::ssb_curs_t curs_out,
   output ssb_pkg::ssb_disp_t disp_out,
   output ssb_pkg::ssb_spec_cfg_t spec_out,
   output ssb_pkg::ssb_sweep_t sweep_out,
   output ssb_pkg::ssb_sniff_cfg_t sniff_out,
   output ssb_pkg::ssb_meter_t meter_out,
   output logic sniffer_mode_out,
   output logic abort_wait_out,
   output logic reload_gen_out,
   output logic reload_acq_out
);
   import ssb_pkg::*;

   // ---------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------

   // Picks the lowest set bit of three and codes it 1 to 3.
   function automatic logic [1:0] pick3(input logic [2:0] b);
      logic [1:0] r;
      r = 2'h0;
      if (b[0]) begin
         r = 2'h1;
      end else if (b[1]) begin
         r = 2'h2;
      end else if (b[2]) begin
         r = 2'h3;
      end
      return r;
   endfunction

   // Turns a baud code into the rate in bits per second.
   function automatic logic [16:0] baud_of(input ssb_baud_t c);
      logic [16:0] r;
      r = `SSB_BAUD_1200;
      case (c)
         BAUD_2400: r = `SSB_BAUD_2400;
         BAUD_4800: r = `SSB_BAUD_4800;
         BAUD_9600: r = `SSB_BAUD_9600;
         BAUD_19200: r = `SSB_BAUD_19200;
         BAUD_38400: r = `SSB_BAUD_38400;
         BAUD_57600: r = `SSB_BAUD_57600;
         BAUD_115200: r = `SSB_BAUD_115200;
         default: r = `SSB_BAUD_1200;
      endcase
      return r;
   endfunction

   // ---------------------------------------------------------
   // Write decode
   // ---------------------------------------------------------
   logic wr_ok;
   logic wr_low;
   logic wr_high;
   logic stat_wr;
   ssb_stat_t wr_stat;

   // A write only counts while the clock enable is high.
   assign wr_ok = ce_in && wr_en_in;
   assign wr_low = wr_ok && (idx_in < `SSB_IDX_ACQ_LIM);
   assign wr_high = wr_ok && (idx_in > `SSB_IDX_GEN_LIM);
   assign stat_wr = wr_ok && (idx_in == `SSB_IDX_STAT);
   assign wr_stat = ssb_stat_t'(wr_data_in);

   // ---------------------------------------------------------
   // Plain setting bytes
   // ---------------------------------------------------------

   // Channel bytes drive the analog front end directly.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ch1_out <= ssb_chan_t'(`SSB_BYTE_RST);
         ch2_out <= ssb_chan_t'(`SSB_BYTE_RST);
      end else if (wr_ok && idx_in == `SSB_IDX_CH1) begin
         ch1_out <= ssb_chan_t'(wr_data_in);
      end else if (wr_ok && idx_in == `SSB_IDX_CH2) begin
         ch2_out <= ssb_chan_t'(wr_data_in);
      end
   end

   // Logic input byte steers pulls, traces and decoders.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         logic_out <= ssb_logic_t'(`SSB_BYTE_RST);
      end else if (wr_ok && idx_in == `SSB_IDX_LOGIC) begin
         logic_out <= ssb_logic_t'(wr_data_in);
      end
   end

   // Display byte holds grid style and drawing options.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         disp_out <= ssb_disp_t'(`SSB_BYTE_RST);
      end else if (wr_ok && idx_in == `SSB_IDX_DISP) begin
         disp_out <= ssb_disp_t'(wr_data_in);
      end
   end

   // Sweep byte goes to the generator sweep engine.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sweep_out <= ssb_sweep_t'(`SSB_BYTE_RST);
      end else if (wr_ok && idx_in == `SSB_IDX_SWEEP) begin
         sweep_out <= ssb_sweep_t'(wr_data_in);
      end
   end

   // ---------------------------------------------------------
   // Bytes kept raw and decoded a cycle later
   // ---------------------------------------------------------
   ssb_trig_t trig_r;
   ssb_curs_t curs_r;
   ssb_spec_t spec_r;
   ssb_sniff_t sniff_r;

   // Raw copies of the bytes that need decoding.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         trig_r <= ssb_trig_t'(`SSB_BYTE_RST);
         curs_r <= ssb_curs_t'(`SSB_BYTE_RST);
         spec_r <= ssb_spec_t'(`SSB_BYTE_RST);
         sniff_r <= ssb_sniff_t'(`SSB_BYTE_RST);
      end else if (wr_ok) begin
         if (idx_in == `SSB_IDX_TRIG) begin
            trig_r <= ssb_trig_t'(wr_data_in);
         end else if (idx_in == `SSB_IDX_CURS) begin
            curs_r <= ssb_curs_t'(wr_data_in);
         end else if (idx_in == `SSB_IDX_SPEC) begin
            spec_r <= ssb_spec_t'(wr_data_in);
         end else if (idx_in == `SSB_IDX_SNIFF) begin
            sniff_r <= ssb_sniff_t'(wr_data_in);
         end
      end
   end

   // Trigger view: single shot needs normal, one mode wins.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         trig_out <= '0;
      end else if (ce_in) begin
         trig_out.mode <= ssb_trig_mode_t'(pick3({trig_r.edge_sel,
            trig_r.window, trig_r.slope}));
         trig_out.normal <= trig_r.normal;
         trig_out.single_eff <= trig_r.single && trig_r.normal;
         trig_out.auto_trig <= trig_r.auto_trig;
         trig_out.dir <= trig_r.dir;
         trig_out.round <= trig_r.round;
      end
   end

   // Cursor view: channel one horizontal cursors win a clash.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         curs_out <= ssb_curs_t'(`SSB_BYTE_RST);
      end else if (ce_in) begin
         curs_out <= curs_r;
         curs_out.h2 <= curs_r.h2 && !curs_r.h1;
      end
   end

   // Spectrum view: one window at most, meter when no view.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         spec_out <= '0;
      end else if (ce_in) begin
         spec_out.win <= ssb_win_t'(pick3({spec_r.blackman,
            spec_r.hann, spec_r.hamming}));
         spec_out.vlog <= spec_r.vlog;
         spec_out.iq <= spec_r.iq;
         spec_out.scope <= spec_r.scope;
         spec_out.xy <= spec_r.xy;
         spec_out.fft <= spec_r.fft;
         spec_out.meter <= !(spec_r.scope || spec_r.xy
            || spec_r.fft);
      end
   end

   // Sniffer framing: baud rate, clock mode, parity and stop bits.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sniff_out <= '0;
      end else if (ce_in) begin
         sniff_out.baud_rate <= baud_of(sniff_r.baud);
         sniff_out.clock_pol <= sniff_r.clock_pol;
         sniff_out.clock_phase <= sniff_r.clock_phase;
         sniff_out.parity_en <= sniff_r.parity_en;
         sniff_out.odd <= sniff_r.odd;
         sniff_out.two_stop <= sniff_r.two_stop;
      end
   end

   // ---------------------------------------------------------
   // Run status byte
   // ---------------------------------------------------------
   logic abort_f;
   logic upd_gen_f;
   logic upd_acq_f;
   logic vdc_r;
   logic vpp_r;
   logic stopped_r;
   logic trig_seen_r;

   // Request flags live until the next cycle consumes them, and a
   // new request in the consuming cycle re-arms the flag.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         abort_f <= 1'b0;
         upd_gen_f <= 1'b0;
         upd_acq_f <= 1'b0;
      end else if (ce_in) begin
         abort_f <= stat_wr && wr_stat.abort;
         upd_gen_f <= (stat_wr && wr_stat.upd_gen) || wr_high;
         upd_acq_f <= (stat_wr && wr_stat.upd_acq) || wr_low;
      end
   end

   // One-cycle actions follow each raised flag.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         abort_wait_out <= 1'b0;
         reload_gen_out <= 1'b0;
         reload_acq_out <= 1'b0;
      end else if (ce_in) begin
         abort_wait_out <= abort_f;
         reload_gen_out <= upd_gen_f;
         reload_acq_out <= upd_acq_f;
      end
   end

   // Mode bits that the host keeps.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sniffer_mode_out <= 1'b0;
         vdc_r <= 1'b0;
         vpp_r <= 1'b0;
      end else if (stat_wr) begin
         sniffer_mode_out <= wr_stat.go_sniffer;
         vdc_r <= wr_stat.vdc;
         vpp_r <= wr_stat.vpp;
      end
   end

   // Meter choice, DC voltage winning over peak-to-peak.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meter_out <= MTR_FREQ;
      end else if (ce_in) begin
         meter_out <= ssb_meter_t'(pick3({1'b0, vpp_r, vdc_r}));
      end
   end

   // Acquisition state reported back in the status byte.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         stopped_r <= 1'b0;
         trig_seen_r <= 1'b0;
      end else if (ce_in) begin
         stopped_r <= acq_stopped_in;
         trig_seen_r <= triggered_in;
      end
   end

   // ---------------------------------------------------------
   // Read back
   // ---------------------------------------------------------
   ssb_stat_t stat_view;
   logic [7:0] next_rd;

   // Status byte as the host sees it.
   assign stat_view = '{vpp: vpp_r, vdc: vdc_r,
      triggered: trig_seen_r, stopped: stopped_r,
      go_sniffer: sniffer_mode_out, upd_acq: upd_acq_f,
      upd_gen: upd_gen_f, abort: abort_f};

   // Indices outside the bitfield bytes read as zero.
   always_comb begin
      next_rd = 8'h00;
      if (idx_in == `SSB_IDX_CH1) begin
         next_rd = ch1_out;
      end else if (idx_in == `SSB_IDX_CH2) begin
         next_rd = ch2_out;
      end else if (idx_in == `SSB_IDX_LOGIC) begin
         next_rd = logic_out;
      end else if (idx_in == `SSB_IDX_TRIG) begin
         next_rd = trig_r;
      end else if (idx_in == `SSB_IDX_CURS) begin
         next_rd = curs_r;
      end else if (idx_in == `SSB_IDX_DISP) begin
         next_rd = disp_out;
      end else if (idx_in == `SSB_IDX_SPEC) begin
         next_rd = spec_r;
      end else if (idx_in == `SSB_IDX_SWEEP) begin
         next_rd = sweep_out;
      end else if (idx_in == `SSB_IDX_SNIFF) begin
         next_rd = sniff_r;
      end else if (idx_in == `SSB_IDX_STAT) begin
         next_rd = stat_view;
      end
   end

   // Read data is registered and holds until the next read.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_data_out <= 8'h00;
      end else if (ce_in && rd_en_in) begin
         rd_data_out <= next_rd;
      end
   end

   // ---------------------------------------------------------
   // Checks
   // ---------------------------------------------------------

   // A low-index write and the following enabled cycle.
   sequence s_low_write;
      wr_low ##1 ce_in;
   endsequence

   // A high-index write and the following enabled cycle.
   sequence s_high_write;
      wr_high ##1 ce_in;
   endsequence

   // An abort request and the following enabled cycle.
   sequence s_abort_req;
      (stat_wr && wr_stat.abort) ##1 ce_in;
   endsequence

   single_gate_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      trig_out.single_eff |-> trig_out.normal)
      else $error("single trigger active without normal trigger");

   trig_dual_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && !trig_r.slope && !trig_r.window && !trig_r.edge_sel)
      |=> trig_out.mode == TRIG_DUAL)
      else $error("dual edge not chosen with mode bits clear");

   acq_update_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      s_low_write |=> reload_acq_out)
      else $error("low index write gave no acquisition reload");

   gen_update_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      s_high_write |=> reload_gen_out)
      else $error("high index write gave no generator reload");

   abort_pulse_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      s_abort_req |=> abort_wait_out)
      else $error("abort request did not end the trigger wait");

   meter_pick_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && vdc_r) |=> meter_out == MTR_VDC)
      else $error("meter did not pick DC voltage");

   window_pick_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && spec_r.hamming) |=> spec_out.win == WIN_HAMMING)
      else $error("lowest window bit did not win");

   cursor_excl_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      !(curs_out.h1 && curs_out.h2))
      else $error("both horizontal cursors enabled");

   meter_view_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && $past(ce_in) && spec_out.meter)
      |-> !$past(spec_r.scope) && !$past(spec_r.xy))
      else $error("meter shown while a view was enabled");

   baud_top_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && sniff_r.baud == BAUD_115200)
      |=> sniff_out.baud_rate == `SSB_BAUD_115200)
      else $error("fastest baud code gave the wrong rate");

   freeze_hold_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      !ce_in |=> $stable(rd_data_out) && $stable(stopped_r))
      else $error("state moved while the clock enable was low");

endmodule

// *** test/ssb_host.sv ***
// Host side model that writes and reads setting bytes of the bank.
module ssb_host (
   input wire logic clk_in,
   input wire logic [7:0] rd_data_in,
   output logic ce_out,
   output logic wr_en_out,
   output logic rd_en_out,
   output logic [5:0] idx_out,
   output logic [7:0] wr_data_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------
   // Bus tasks
   // ------------------------------------------------------------
   // Idle state before the first request.
   initial begin
      ce_out = 1'b1;
      wr_en_out = 1'b0;
      rd_en_out = 1'b0;
      idx_out = 6'h00;
      wr_data_out = 8'h00;
   end
   // One byte write; data toggles away once the strobe is released.
   // Callers also write single without normal and clashing selections.
   task automatic wr(input logic c, input logic [5:0] i, input logic [7:0] d);
      @(posedge clk_in);
      ce_out <= c;
      wr_en_out <= 1'b1;
      idx_out <= i;
      wr_data_out <= d;
      @(posedge clk_in);
      ce_out <= 1'b1;
      wr_en_out <= 1'b0;
      wr_data_out <= ~d;
   endtask
   // One byte read; read data stands from the edge that takes the
   // request until the next read, so it is picked up one edge later.
   // Returning on an edge lets the caller drive its inputs there.
   task automatic rd(input logic [5:0] i, output logic [7:0] d);
      @(posedge clk_in);
      rd_en_out <= 1'b1;
      idx_out <= i;
      @(posedge clk_in);
      rd_en_out <= 1'b0;
      @(posedge clk_in);
      d = rd_data_in;
   endtask
endmodule

// *** test/tb.sv ***
// Self-checking bench for the settings bank.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ssb_pkg::*;
   logic clk, rst, ce, wr_en, rd_en, stop_i, trig_i, snf, abrt, rgen, racq;
   logic [5:0] idx;
   logic [7:0] wd, rdd, got, n_ab, n_gen, n_acq;
   logic cnt_clr;
   ssb_chan_t ch1, ch2;
   ssb_logic_t lgc;
   ssb_trig_cfg_t trg;
   ssb_curs_t cur;
   ssb_disp_t dsp;
   ssb_spec_cfg_t spc;
   ssb_sweep_t swp;
   ssb_sniff_cfg_t snc;
   ssb_meter_t mtr;
   int err_count = 0;
   int checks_done = 0;
   // Rows: enable, index, data, view select, expected view.
   localparam logic [50:0] ROWS [35] = '{
      {1'b1, 6'h01, 8'hd1, 4'h0, 32'hd1},
      {1'b1, 6'h02, 8'h70, 4'h1, 32'h70},
      {1'b0, 6'h01, 8'h00, 4'h0, 32'hd1},
      {1'b1, 6'h03, 8'hfe, 4'h2, 32'hfe},
      {1'b1, 6'h05, 8'h03, 4'h3, 32'h18},
      {1'b1, 6'h05, 8'h02, 4'h3, 32'h00},
      {1'b1, 6'h05, 8'h3c, 4'h3, 32'h27},
      {1'b1, 6'h05, 8'h40, 4'h3, 32'h40},
      {1'b1, 6'h05, 8'h80, 4'h3, 32'h60},
      {1'b1, 6'h05, 8'he0, 4'h3, 32'h20},
      {1'b1, 6'h06, 8'h18, 4'h4, 32'h08},
      {1'b1, 6'h06, 8'he7, 4'h4, 32'he7},
      {1'b1, 6'h07, 8'h7c, 4'h5, 32'h7c},
      {1'b1, 6'h07, 8'h81, 4'h5, 32'h81},
      {1'b1, 6'h07, 8'h02, 4'h5, 32'h02},
      {1'b1, 6'h07, 8'h43, 4'h5, 32'h43},
      {1'b1, 6'h08, 8'h01, 4'h6, 32'h41},
      {1'b1, 6'h08, 8'h02, 4'h6, 32'h81},
      {1'b1, 6'h08, 8'h04, 4'h6, 32'hc1},
      {1'b1, 6'h08, 8'he0, 4'h6, 32'h0e},
      {1'b1, 6'h08, 8'h06, 4'h6, 32'h81},
      {1'b1, 6'h09, 8'ha5, 4'h7, 32'ha5},
      {1'b1, 6'h0a, 8'h00, 4'h8, 32'h9600},
      {1'b1, 6'h0a, 8'ha9, 4'h8, 32'h12c15},
      {1'b1, 6'h0a, 8'h52, 4'h8, 32'h2580a},
      {1'b1, 6'h0a, 8'h03, 4'h8, 32'h4b000},
      {1'b1, 6'h0a, 8'h04, 4'h8, 32'h96000},
      {1'b1, 6'h0a, 8'h05, 4'h8, 32'h12c000},
      {1'b1, 6'h0a, 8'h06, 4'h8, 32'h1c2000},
      {1'b1, 6'h0a, 8'h07, 4'h8, 32'h384000},
      {1'b1, 6'h0b, 8'h40, 4'h9, 32'h1},
      {1'b1, 6'h0b, 8'h80, 4'h9, 32'h2},
      {1'b1, 6'h0b, 8'hc0, 4'h9, 32'h1},
      {1'b1, 6'h0b, 8'h00, 4'h9, 32'h0},
      {1'b1, 6'h0b, 8'h08, 4'ha, 32'h1}
   };
   // Pulse rows: index, data, expected abort, generator, acquisition.
   localparam logic [16:0] PULSES [7] = '{
      {6'h0b, 8'h01, 3'b101}, {6'h0b, 8'h02, 3'b011}, {6'h0b, 8'h04, 3'b001},
      {6'h0d, 8'h00, 3'b001}, {6'h0e, 8'h00, 3'b000}, {6'h22, 8'h00, 3'b000},
      {6'h23, 8'h00, 3'b010}
   };
   localparam logic [7:0] BACK [9] = '{8'hd1, 8'h70, 8'hfe, 8'h00, 8'he0,
      8'he7, 8'h43, 8'h06, 8'ha5};
   // ------------------------------------------------------------
   // Instances
   // ------------------------------------------------------------
   ssb_host host (.clk_in(clk), .rd_data_in(rdd), .ce_out(ce),
      .wr_en_out(wr_en), .rd_en_out(rd_en), .idx_out(idx), .wr_data_out(wd));
   ssb_bank dut (.clk_in(clk), .rst_in(rst), .ce_in(ce), .wr_en_in(wr_en),
      .rd_en_in(rd_en), .idx_in(idx), .wr_data_in(wd),
      .acq_stopped_in(stop_i), .triggered_in(trig_i), .rd_data_out(rdd),
      .ch1_out(ch1), .ch2_out(ch2), .logic_out(lgc), .trig_out(trg),
      .curs_out(cur), .disp_out(dsp), .spec_out(spc), .sweep_out(swp),
      .sniff_out(snc), .meter_out(mtr), .sniffer_mode_out(snf),
      .abort_wait_out(abrt), .reload_gen_out(rgen), .reload_acq_out(racq));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Clock at 50 ns period.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Counts cycles each pulse output is high; cnt_clr empties the counts.
   always @(posedge clk) begin
      if (cnt_clr) begin
         n_ab <= 8'h00;
         n_gen <= 8'h00;
         n_acq <= 8'h00;
      end else begin
         n_ab <= n_ab + {7'h00, abrt};
         n_gen <= n_gen + {7'h00, rgen};
         n_acq <= n_acq + {7'h00, racq};
      end
   end
   // Picks one decoded output, zero extended.
   function automatic logic [31:0] view(input logic [3:0] s);
      case (s)
         4'h0: view = {24'h0, ch1};
         4'h1: view = {24'h0, ch2};
         4'h2: view = {24'h0, lgc};
         4'h3: view = {25'h0, trg};
         4'h4: view = {24'h0, cur};
         4'h5: view = {24'h0, dsp};
         4'h6: view = {24'h0, spc};
         4'h7: view = {24'h0, swp};
         4'h8: view = {10'h0, snc};
         4'h9: view = {30'h0, mtr};
         default: view = {31'h0, snf};
      endcase
   endfunction
   // Compares one value and reports a mismatch.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Prints the verdict and ends the run.
   task automatic tally_and_finish;
      if (err_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      repeat (4000) @(posedge clk);
      err_count++;
      tally_and_finish;
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      stop_i = 1'b0;
      trig_i = 1'b0;
      cnt_clr = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk(view(4'h3), 32'h0);
      chk(view(4'h6), 32'h01);
      chk(view(4'h8), 32'h9600);
      chk(view(4'h9), 32'h0);
      foreach (ROWS[k]) begin
         host.wr(ROWS[k][50], ROWS[k][49:44], ROWS[k][43:36]);
         repeat (3) @(posedge clk);
         #1 chk(view(ROWS[k][35:32]), ROWS[k][31:0]);
      end
      foreach (BACK[k]) begin
         host.rd(6'(k + 1), got);
         if (k != 3)
            chk({24'h0, got}, {24'h0, BACK[k]});
         else
            chk({24'h0, got}, 32'h0);
      end
      stop_i <= 1'b1;
      host.rd(6'h0b, got);
      chk({24'h0, got}, 32'h18);
      stop_i <= 1'b0;
      trig_i <= 1'b1;
      repeat (2) @(posedge clk);
      host.rd(6'h0b, got);
      chk({24'h0, got}, 32'h28);
      host.rd(6'h2a, got);
      chk({24'h0, got}, 32'h0);
      foreach (PULSES[k]) begin
         repeat (4) @(posedge clk);
         cnt_clr <= 1'b1;
         @(posedge clk);
         cnt_clr <= 1'b0;
         host.wr(1'b1, PULSES[k][16:11], PULSES[k][10:3]);
         repeat (5) @(posedge clk);
         #1 chk({8'h0, n_ab, n_gen, n_acq}, {15'h0, PULSES[k][2], 7'h0,
            PULSES[k][1], 7'h0, PULSES[k][0]});
      end
      // A reset in mid-run empties the bytes and the decoded views.
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(view(4'h0), 32'h0);
      chk(view(4'h3), 32'h0);
      tally_and_finish;
   end
endmodule
